// ---- snu_defines.svh ----
// offsets, reset values and exponent constants of the normalize unit
`ifndef SNU_DEFINES_SVH
`define SNU_DEFINES_SVH

// register port offsets (word index on reg_addr_i)
`define SNU_OFF_EXP 4'h0
`define SNU_OFF_RES_LOW 4'h1
`define SNU_OFF_RES_MID 4'h2
`define SNU_OFF_RES_GUARD 4'h3
`define SNU_OFF_REF_SIGN 4'h4

// reset values
`define SNU_EXP_RST 16'h0000
`define SNU_RES_RST 40'h00_0000_0000
`define SNU_SIGN_RST 1'b0
`define SNU_RDATA_RST 16'h0000

// exponent landmarks: minus fifteen (top word all sign) and plus one
`define SNU_EXP_ALL_SIGN 16'hFFF1
`define SNU_EXP_OVF 16'h0001

// smallest shift code that pushes the operand off scale
`define SNU_CODE_OFF_SCALE 8'h10
// bit position of the middle result word
`define SNU_TOP_BASE 10'h010
`define SNU_LOW_BASE 10'h000

`endif

// ---- snu_pkg.sv ----
// types shared by the normalize unit modules
package snu_pkg;
  typedef enum logic {SNU_OP_EXP, SNU_OP_NORM} snu_op_t;
  typedef enum logic [1:0] {
    SNU_REF_TOP,
    SNU_REF_BOTTOM,
    SNU_REF_TOP_OVF
  } snu_ref_t;
endpackage : snu_pkg

// ---- snu_exp_detect.sv ----
// exponent detector: redundant sign bit count of a 16-bit operand
`timescale 1ns/1ns
`default_nettype none
`include "snu_defines.svh"
module snu_exp_detect
  import snu_pkg::*;
(
  input wire logic [15:0] operand_i,
  input wire snu_ref_t ref_i,
  input wire logic ovf_i,
  input wire logic ref_sign_i,
  input wire logic [15:0] exp_cur_i,
  output logic exp_load_o,
  output logic [15:0] exp_val_o,
  output logic sign_load_o,
  output logic sign_val_o
);
  // leading bits equal to s, 0..16
  function automatic logic [4:0] lead_cnt(input logic [15:0] v,
                                          input logic s);
    logic run;
    logic [4:0] n;
    run = 1'b1;
    n = 5'h00;
    for (int i = 15; i >= 0; i--)
    begin
      run = run & (v[i] == s);
      n = n + {4'h0, run};
    end
    return n;
  endfunction : lead_cnt

  logic [4:0] top_n;
  logic [4:0] low_n;

  assign top_n = lead_cnt(operand_i, operand_i[15]);
  // lower word is judged against the sign of the upper word
  assign low_n = lead_cnt(operand_i, ref_sign_i);

  // 16-bit subtraction wraps, which sign-extends the exponent for free
  always_comb
  begin
    exp_load_o = 1'b1;
    sign_load_o = 1'b1;
    sign_val_o = operand_i[15];
    exp_val_o = `SNU_EXP_OVF - {11'h000, top_n};
    unique case (ref_i)
      SNU_REF_TOP: ;
      SNU_REF_TOP_OVF:
        if (ovf_i)
        begin
          exp_val_o = `SNU_EXP_OVF;
          sign_val_o = ~operand_i[15];
        end
      SNU_REF_BOTTOM:
      begin
        sign_load_o = 1'b0;
        exp_load_o = (exp_cur_i == `SNU_EXP_ALL_SIGN);
        exp_val_o = `SNU_EXP_ALL_SIGN - {11'h000, low_n};
      end
      default:
      begin
        exp_load_o = 1'b0;
        sign_load_o = 1'b0;
      end
    endcase
  end
endmodule : snu_exp_detect
`default_nettype wire

// ---- snu_shift_array.sv ----
// 16x40 placement array: operand placed by signed code around a base
`timescale 1ns/1ns
`default_nettype none
`include "snu_defines.svh"
module snu_shift_array (
  input wire logic [15:0] data_i,
  input wire logic [7:0] code_i,
  input wire logic top_ref_i,
  input wire logic ext_i,
  output logic [39:0] shifted_o
);
  logic signed [9:0] base;
  logic off_scale;

  // middle word for top reference, low word for bottom
  assign base = $signed(top_ref_i ? `SNU_TOP_BASE : `SNU_LOW_BASE);
  assign off_scale = $signed(code_i) >= $signed(`SNU_CODE_OFF_SCALE);

  // per output bit: index k into the operand, ext above, zero below
  genvar j;
  generate
    for (j = 0; j < 40; j++)
    begin : g_bit
      logic signed [9:0] k;
      assign k = $signed(10'(j)) - base - 10'($signed(code_i));
      assign shifted_o[j] = off_scale ? 1'b0 :
                            (k < 10'sh000) ? 1'b0 :
                            (k > 10'sh00F) ? ext_i : data_i[k[3:0]];
    end
  endgenerate
endmodule : snu_shift_array
`default_nettype wire

// ---- snu_top.sv ----
// normalize unit: exponent derivation and mantissa align, with registers
// Contract
// - normalize shifts operand so rightmost sign bit reaches field MSB
// - sign count loads exponent register; top and bottom modifiers accepted
// - mantissa align uses negated exponent register as shift code
// - align supports top/bottom modifiers and OR into current result
// - single precision result lands in middle word (top) or low (bottom)
// - overflow-aware mode reads overflow and carry; carry is true sign
// - overflow-aware mode with overflow set loads exponent plus one
// - align shifts in carry whenever exponent is plus one, no overflow check
// - overflow-aware mode without overflow equals plain top-half mode
// - extension bit is zero for bottom except at exponent plus one, carry for top modifier
// - bottom derivation changes exponent only when it holds minus fifteen
// - exponent from minus sixteen to minus 127 moves operand completely off scale
// - top-half exponent is minus the redundant sign bit count
// - positive code shifts left, negative right; code is 8-bit signed
// - top reference is middle word, bottom reference is low word
// - low 8 exponent bits steer the shift, all 16 bits the plus-one carry test; derived exponents sign-extended
`timescale 1ns/1ns
`default_nettype none
`include "snu_defines.svh"
module snu_top
  import snu_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic op_valid_i,
  input wire snu_op_t op_kind_i,
  input wire snu_ref_t ref_i,
  input wire logic merge_i,
  input wire logic [15:0] operand_i,
  input wire logic alu_overflow_flag_i,
  input wire logic alu_carry_flag_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic [15:0] shift_exponent_o,
  output logic [39:0] shift_result_o
);
  logic [15:0] shift_exponent_reg_q;
  logic [39:0] shift_result_reg_q;
  logic [39:0] shift_result_reg_d;
  logic ref_sign_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  logic exp_go;
  logic norm_go;
  logic top_ref;
  logic [7:0] norm_code;
  logic ext_bit;
  logic [39:0] shifted;
  logic det_exp_load;
  logic [15:0] det_exp_val;
  logic det_sign_load;
  logic det_sign_val;

  // bus write decodes
  logic wr_exp;
  logic wr_low;
  logic wr_mid;
  logic wr_guard;
  logic wr_sign;

  // operation strobes; one operation per cycle
  assign exp_go = op_valid_i && (op_kind_i == SNU_OP_EXP);
  assign norm_go = op_valid_i && (op_kind_i == SNU_OP_NORM);
  // overflow-aware modifier aligns like the plain top half
  assign top_ref = (ref_i != SNU_REF_BOTTOM);

  assign wr_exp = reg_wr_i && (reg_addr_i == `SNU_OFF_EXP);
  assign wr_low = reg_wr_i && (reg_addr_i == `SNU_OFF_RES_LOW);
  assign wr_mid = reg_wr_i && (reg_addr_i == `SNU_OFF_RES_MID);
  assign wr_guard = reg_wr_i && (reg_addr_i == `SNU_OFF_RES_GUARD);
  assign wr_sign = reg_wr_i && (reg_addr_i == `SNU_OFF_REF_SIGN);

  // align code: negated low byte of the exponent register
  assign norm_code = 8'(8'h00 - shift_exponent_reg_q[7:0]);

  // carry enters on top reference, and always when exponent is plus one;
  // overflow is not consulted so an explicit exponent load also works
  assign ext_bit = (top_ref ||
                    shift_exponent_reg_q == `SNU_EXP_OVF) ?
                   alu_carry_flag_i : 1'b0;

  snu_exp_detect u_exp_detect (
    .operand_i(operand_i),
    .ref_i(ref_i),
    .ovf_i(alu_overflow_flag_i),
    .ref_sign_i(ref_sign_q),
    .exp_cur_i(shift_exponent_reg_q),
    .exp_load_o(det_exp_load),
    .exp_val_o(det_exp_val),
    .sign_load_o(det_sign_load),
    .sign_val_o(det_sign_val)
  );

  snu_shift_array u_shift_array (
    .data_i(operand_i),
    .code_i(norm_code),
    .top_ref_i(top_ref),
    .ext_i(ext_bit),
    .shifted_o(shifted)
  );

  // exponent register: derivation wins over a same-cycle bus write
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      shift_exponent_reg_q <= `SNU_EXP_RST;
    else if (exp_go && det_exp_load)
      shift_exponent_reg_q <= det_exp_val;
    else if (wr_exp)
      shift_exponent_reg_q <= reg_wdata_i;
  end

  // sign of the upper word, kept for the following bottom derivation
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ref_sign_q <= `SNU_SIGN_RST;
    else if (exp_go && det_sign_load)
      ref_sign_q <= det_sign_val;
    else if (wr_sign)
      ref_sign_q <= reg_wdata_i[0];
  end

  // result next value: align overwrites or merges, bus writes per word
  always_comb
  begin
    shift_result_reg_d = shift_result_reg_q;
    if (norm_go)
    begin
      if (merge_i)
        shift_result_reg_d = shift_result_reg_q | shifted;
      else
        shift_result_reg_d = shifted;
    end
    else
    begin
      if (wr_low)
        shift_result_reg_d[15:0] = reg_wdata_i;
      if (wr_mid)
        shift_result_reg_d[31:16] = reg_wdata_i;
      if (wr_guard)
        shift_result_reg_d[39:32] = reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      shift_result_reg_q <= `SNU_RES_RST;
    else
      shift_result_reg_q <= shift_result_reg_d;
  end

  // read mux; guard word and sign sit in low bits, rest reads zero
  always_comb
  begin
    rdata_d = 16'h0000;
    unique case (reg_addr_i)
      `SNU_OFF_EXP: rdata_d = shift_exponent_reg_q;
      `SNU_OFF_RES_LOW: rdata_d = shift_result_reg_q[15:0];
      `SNU_OFF_RES_MID: rdata_d = shift_result_reg_q[31:16];
      `SNU_OFF_RES_GUARD: rdata_d = {8'h00, shift_result_reg_q[39:32]};
      `SNU_OFF_REF_SIGN: rdata_d = {15'h0000, ref_sign_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_q <= `SNU_RDATA_RST;
    else if (reg_rd_i)
      rdata_q <= rdata_d;
    else
      rdata_q <= `SNU_RDATA_RST;
  end

  assign reg_rdata_o = rdata_q;
  assign shift_exponent_o = shift_exponent_reg_q;
  assign shift_result_o = shift_result_reg_q;

  // checks on the datapath, all on the core clock
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  ovf_exp_plus_a: assert property (
    exp_go && ref_i == SNU_REF_TOP_OVF && alu_overflow_flag_i
    |=> shift_exponent_reg_q == `SNU_EXP_OVF)
    else $error("overflow derivation did not load plus one");

  hix_plain_sign_a: assert property (
    exp_go && ref_i == SNU_REF_TOP_OVF && !alu_overflow_flag_i
    |=> ref_sign_q == $past(operand_i[15]))
    else $error("overflow-aware mode used carry without overflow");

  lo_keeps_exp_a: assert property (
    exp_go && ref_i == SNU_REF_BOTTOM &&
    shift_exponent_reg_q != `SNU_EXP_ALL_SIGN && !wr_exp
    |=> $stable(shift_exponent_reg_q))
    else $error("bottom derivation changed exponent");

  top_exp_range_a: assert property (
    exp_go && ref_i == SNU_REF_TOP
    |=> $signed(shift_exponent_reg_q) <= $signed(16'h0000) &&
        $signed(shift_exponent_reg_q) >= $signed(`SNU_EXP_ALL_SIGN))
    else $error("top-half exponent out of range");

  exp_sign_ext_a: assert property (
    exp_go && (ref_i == SNU_REF_TOP ||
               ref_i == SNU_REF_TOP_OVF)
    |=> shift_exponent_reg_q[15:8] == {8{shift_exponent_reg_q[7]}})
    else $error("derived exponent not sign-extended");

  low_place_a: assert property (
    norm_go && !merge_i && ref_i == SNU_REF_BOTTOM &&
    shift_exponent_reg_q == `SNU_EXP_RST
    |=> shift_result_reg_q == {24'h00_0000, $past(operand_i)})
    else $error("bottom align did not land in low word");

  top_place_a: assert property (
    norm_go && !merge_i && top_ref && shift_exponent_reg_q == 16'h0000
    |=> shift_result_reg_q[31:0] == {$past(operand_i), 16'h0000})
    else $error("top align did not land in middle word");

  carry_shift_in_a: assert property (
    norm_go && !merge_i && top_ref &&
    shift_exponent_reg_q == `SNU_EXP_OVF
    |=> shift_result_reg_q[31] == $past(alu_carry_flag_i) &&
        shift_result_reg_q[30:15] == $past(operand_i))
    else $error("carry not shifted in at exponent plus one");

  off_scale_a: assert property (
    norm_go && !merge_i &&
    $signed(shift_exponent_reg_q[7:0]) < $signed(8'hF1) &&
    shift_exponent_reg_q[7:0] != 8'h80 // negated -128 wraps, shifts right
    |=> shift_result_reg_q == `SNU_RES_RST)
    else $error("operand not moved off scale");

  merge_keeps_a: assert property (
    norm_go && merge_i
    |=> (shift_result_reg_q & $past(shift_result_reg_q)) ==
        $past(shift_result_reg_q))
    else $error("merge lost earlier result bits");

  read_one_cycle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data stood without a read strobe");

  // reload after an all-sign upper word lands in -31..-15
  low_reload_a: assert property (
    exp_go && ref_i == SNU_REF_BOTTOM &&
    shift_exponent_reg_q == `SNU_EXP_ALL_SIGN
    |=> $signed(shift_exponent_reg_q) <= $signed(`SNU_EXP_ALL_SIGN) &&
        $signed(shift_exponent_reg_q) >= $signed(16'hFFE1))
    else $error("bottom derivation reload out of range");

  // directed placements at exponents 0, +1 and -1 pin down each word
  low_right_a: assert property (
    norm_go && !merge_i && ref_i == SNU_REF_BOTTOM &&
    shift_exponent_reg_q == `SNU_EXP_OVF
    |=> shift_result_reg_q[14:0] == $past(operand_i[15:1]) &&
        shift_result_reg_q[15] == $past(alu_carry_flag_i))
    else $error("plus one exponent did not shift right with carry");

  low_zero_ext_a: assert property (
    norm_go && !merge_i && ref_i == SNU_REF_BOTTOM &&
    shift_exponent_reg_q == 16'hFFFF
    |=> shift_result_reg_q == {23'h00_0000, $past(operand_i), 1'b0})
    else $error("bottom align extension not zero");

  top_carry_ext_a: assert property (
    norm_go && !merge_i && top_ref && shift_exponent_reg_q == 16'h0000
    |=> shift_result_reg_q[39:32] == {8{$past(alu_carry_flag_i)}})
    else $error("top align extension not carry");

  // scenarios the bench is expected to reach
  ovf_norm_c: cover property (
    exp_go && ref_i == SNU_REF_TOP_OVF && alu_overflow_flag_i
    ##1 norm_go && top_ref);
  low_reload_c: cover property (
    exp_go && ref_i == SNU_REF_BOTTOM &&
    shift_exponent_reg_q == `SNU_EXP_ALL_SIGN);
  double_merge_c: cover property (
    norm_go && !merge_i ##1 norm_go && merge_i);
  off_scale_c: cover property (
    norm_go && $signed(norm_code) >= $signed(`SNU_CODE_OFF_SCALE));
  bottom_ext_c: cover property (
    norm_go && ref_i == SNU_REF_BOTTOM && alu_carry_flag_i);
endmodule : snu_top
`default_nettype wire

// ---- snu_core_model.sv ----
// core-side model: sequencer issuing shifter operations
`timescale 1ns/1ns
`default_nettype none
module snu_core_model
  import snu_pkg::*;
(
  input wire logic clk_i,
  output logic op_valid_o,
  output snu_op_t op_kind_o,
  output snu_ref_t ref_o,
  output logic merge_o,
  output logic [15:0] operand_o,
  output logic ovf_o,
  output logic carry_o
);
  // quiet port at time zero
  initial
  begin
    op_valid_o = 1'b0;
    op_kind_o = SNU_OP_EXP;
    ref_o = SNU_REF_TOP;
    merge_o = 1'b0;
    operand_o = 16'h0000;
    ovf_o = 1'b0;
    carry_o = 1'b0;
  end

  // one operation per edge, so calls may follow back to back
  task automatic issue(input snu_op_t k, input snu_ref_t r, input logic m,
                       input logic [15:0] d, input logic v, input logic c);
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_kind_o <= k;
    ref_o <= r;
    merge_o <= m;
    operand_o <= d;
    ovf_o <= v;
    carry_o <= c;
  endtask : issue

  // released operand shows the inverse, never a stale copy
  task automatic idle();
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    operand_o <= ~operand_o;
  endtask : idle
endmodule : snu_core_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench of the normalize unit
`timescale 1ns/1ns
`default_nettype none
`include "snu_defines.svh"
module testbench
  import snu_pkg::*;
;
  logic clk_i, rst_b_i, rd, wr, op_valid, merge, ovf, carry, m_sign;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, exp_o, d, m_exp;
  logic [39:0] res_o, m_res;
  logic [1:0] r;
  snu_op_t kind;
  snu_ref_t op_ref;
  int failures, compares;
  wire logic [15:0] d_w;

  snu_core_model u_core (.clk_i(clk_i), .op_valid_o(op_valid),
    .op_kind_o(kind), .ref_o(op_ref), .merge_o(merge), .operand_o(d_w),
    .ovf_o(ovf), .carry_o(carry));
  snu_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid),
    .op_kind_i(kind), .ref_i(op_ref), .merge_i(merge), .operand_i(d_w),
    .alu_overflow_flag_i(ovf), .alu_carry_flag_i(carry),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .shift_exponent_o(exp_o), .shift_result_o(res_o));

  // 100 MHz core clock
  always #5 clk_i = ~clk_i;

  // leading bits equal to s
  function automatic logic [4:0] lead(input logic [15:0] v, input logic s);
    lead = 5'h00;
    for (int i = 15; i >= 0 && v[i] === s; i--)
      lead = lead + 5'h01;
  endfunction : lead

  // placement by negated low exponent byte; off scale from code 16 up
  function automatic logic [39:0] f_norm(input logic [15:0] v,
      input logic [15:0] e, input logic top, input logic c);
    logic signed [7:0] code;
    logic ext;
    int p;
    code = -e[7:0];
    ext = (top | (e == 16'h0001)) & c;
    p = (top ? 16 : 0) + code;
    for (int i = 0; i < 40; i++)
      f_norm[i] = (code >= 16 || i < p) ? 1'b0 : (i - p > 15) ? ext : v[i - p];
  endfunction : f_norm

  task automatic chk_res(input logic [39:0] got, input logic [39:0] e);
    compares++;
    if (got !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, e);
    end
  endtask : chk_res

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] e);
    chk_res({24'h000000, got}, {24'h000000, e});
  endtask : chk_reg

  task automatic check_state();
    @(negedge clk_i);
    chk_reg(exp_o, m_exp);
    chk_res(res_o, m_res);
  endtask : check_state

  // issue and mirror one operation in the model
  task automatic op(input logic k, input logic [1:0] g, input logic m,
                    input logic [15:0] v, input logic f, input logic c);
    u_core.issue(snu_op_t'(k), snu_ref_t'(g), m, v, f, c);
    if (k)
      m_res = f_norm(v, m_exp, g != 2'h1, c) | (m ? m_res : 40'h0);
    else if (g == 2'h2 && f)
      m_exp = 16'h0001;
    else if (g == 2'h0 || g == 2'h2)
      m_exp = 16'h0001 - 16'(lead(v, v[15]));
    else if (g == 2'h1 && m_exp == `SNU_EXP_ALL_SIGN)
      m_exp = 16'hFFF1 - 16'(lead(v, m_sign));
    if (!k && (g == 2'h0 || g == 2'h2))
      m_sign = v[15] ^ (g == 2'h2 && f);
  endtask : op

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_i);
    wr <= 1'b0;
    case (a)
      `SNU_OFF_EXP: m_exp = v;
      `SNU_OFF_RES_LOW: m_res[15:0] = v;
      `SNU_OFF_RES_MID: m_res[31:16] = v;
      `SNU_OFF_RES_GUARD: m_res[39:32] = v[7:0];
      `SNU_OFF_REF_SIGN: m_sign = v[0];
      default: ;
    endcase
  endtask : bus_wr

  // read data stand one cycle only
  task automatic bus_rd(input logic [3:0] a);
    logic [15:0] e;
    case (a)
      `SNU_OFF_EXP: e = m_exp;
      `SNU_OFF_RES_LOW: e = m_res[15:0];
      `SNU_OFF_RES_MID: e = m_res[31:16];
      `SNU_OFF_RES_GUARD: e = {8'h00, m_res[39:32]};
      `SNU_OFF_REF_SIGN: e = {15'h0000, m_sign};
      default: e = 16'h0000;
    endcase
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    chk_reg(rdata, e);
    @(negedge clk_i);
    chk_reg(rdata, 16'h0000);
  endtask : bus_rd

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // watchdog: a hang counts as a mismatch
  initial
  begin
    #500000;
    failures++;
    $display("MISMATCH t=%0t watchdog ran out", $time);
    end_sim();
  end

  // main sequence
  initial
  begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    {rd, wr, addr, wdata} = '0;
    {m_exp, m_res, m_sign, failures, compares} = '0;
    void'($urandom(54988));
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    check_state();
    bus_rd(`SNU_OFF_REF_SIGN);
    $display("test reset done");
    op(0, 2'h0, 0, 16'hF6D4, 0, 0);
    op(1, 2'h0, 0, 16'hF6D4, 0, 1);
    u_core.idle();
    check_state();
    chk_res(res_o, 40'hFF_B6A0_0000);
    bus_rd(`SNU_OFF_RES_MID);
    $display("test single done");
    op(0, 2'h2, 0, 16'hFA32, 1, 0);
    op(1, 2'h0, 0, 16'hFA32, 1, 0);
    u_core.idle();
    check_state();
    chk_res(res_o, 40'h00_7D19_0000);
    op(0, 2'h2, 0, 16'hE35B, 0, 1);
    u_core.idle();
    check_state();
    chk_reg(exp_o, 16'hFFFE);
    bus_wr(`SNU_OFF_EXP, 16'h0001);
    op(1, 2'h1, 0, 16'h8000, 0, 1);
    u_core.idle();
    check_state();
    bus_wr(`SNU_OFF_EXP, 16'h0000);
    op(1, 2'h1, 0, 16'hB6A3, 0, 1);
    op(1, 2'h0, 0, 16'hB6A3, 0, 1);
    u_core.idle();
    check_state();
    chk_res(res_o, 40'hFF_B6A3_0000);
    bus_wr(`SNU_OFF_EXP, 16'hFFFF);
    op(1, 2'h1, 0, 16'hB6A3, 0, 1);
    u_core.idle();
    check_state();
    chk_res(res_o, 40'h00_0001_6D46);
    $display("test overflow done");
    op(0, 2'h0, 0, 16'hF6D4, 0, 0);
    op(0, 2'h1, 0, 16'h6ECB, 0, 0);
    op(1, 2'h0, 0, 16'hF6D4, 0, 1);
    op(1, 2'h1, 1, 16'h6ECB, 0, 1);
    u_core.idle();
    check_state();
    op(0, 2'h0, 0, 16'hFFFF, 0, 0);
    op(0, 2'h1, 0, 16'hF6D4, 0, 0);
    op(1, 2'h0, 0, 16'hFFFF, 0, 1);
    op(1, 2'h1, 1, 16'hF6D4, 0, 1);
    op(0, 2'h3, 0, 16'h0001, 0, 0);
    u_core.idle();
    check_state();
    chk_reg(exp_o, 16'hFFED);
    $display("test double done");
    // random mix of operations and register traffic
    repeat (300)
    begin
      d = 16'($signed(16'($urandom)) >>> $urandom_range(0, 15));
      r = 2'($urandom_range(0, 3));
      case ($urandom_range(0, 3))
        0: op(0, r, 0, d, 1'($urandom), 1'($urandom));
        1: op(1, 2'($urandom_range(0, 2)), 1'($urandom), d, 0, 1'($urandom));
        2: bus_wr(4'($urandom_range(0, 4)), 16'($urandom));
        default: bus_rd(4'($urandom_range(0, 5)));
      endcase
      u_core.idle();
      check_state();
    end
    $display("test random done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
